// *** design/upc_pkg.sv ***
// Package: register map, field layout and carrier types of the USB pad and regulator control block
package upc_pkg;

   // Register port widths
   localparam int unsigned UPC_ADDR_W = 8;
   localparam int unsigned UPC_DATA_W = 8;

   // Register offsets
   localparam logic [UPC_ADDR_W-1:0] UPC_OFF_REGULATOR_CONTROL = 8'h73;
   localparam logic [UPC_ADDR_W-1:0] UPC_OFF_TRANSCEIVER_CONFIG = 8'h74;
   localparam logic [UPC_ADDR_W-1:0] UPC_OFF_PAD_STATUS = 8'h75;

   // Reset values
   localparam logic [UPC_DATA_W-1:0] UPC_RST_REGULATOR_CONTROL = 8'h00;
   localparam logic [UPC_DATA_W-1:0] UPC_RST_TRANSCEIVER_CONFIG = 8'h00;
   localparam logic [UPC_DATA_W-1:0] UPC_RST_READ_DATA = 8'h00;

   // Transceiver configuration fields
   localparam int unsigned UPC_XCVR_PULLUP_BIT = 7;
   localparam int unsigned UPC_XCVR_FORCE_BIT = 0;

   // Regulator control fields
   localparam int unsigned UPC_REGULATOR_OUTPUT_ENABLE_BIT = 0;
   localparam int unsigned UPC_REGULATOR_OUTPUT_KEEP_ALIVE_BIT = 1;

   // Pad status fields (read only)
   localparam int unsigned UPC_STAT_FORCE_ACTIVE_BIT = 0;
   localparam int unsigned UPC_STAT_PULLUP_ON_BIT = 1;
   localparam int unsigned UPC_STAT_POWER_DOWN_BIT = 2;
   localparam int unsigned UPC_STAT_GPIO_TAKEN_BIT = 3;

   // Alternate drive covers port 1 pins 3 to 6
   localparam int unsigned UPC_ALT_PINS = 4;
   localparam int unsigned UPC_ALT_FIRST_PIN = 3;

   // Keep-alive source limit, microamps, for reference by the analog side
   localparam int unsigned UPC_KEEP_ALIVE_LIMIT_UA = 20;

   // Register port request
   typedef struct packed {
      logic [UPC_ADDR_W-1:0] addr;
      logic [UPC_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } upc_bus_req_s;

   // Level pair of the USB bus lines
   typedef struct packed {
      logic dp;
      logic dm;
   } upc_pad_s;

   // Drive request for the USB bus lines; oe_n low means drive
   typedef struct packed {
      logic dp;
      logic dm;
      logic oe_n;
   } upc_pad_drive_s;

endpackage

// *** design/upc_sync2.sv ***
// Two-stage synchroniser for the D+/D- receive levels
`timescale 1ns/100ps
`default_nettype none
module upc_sync2
   import upc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire upc_pad_s d_i,
   output upc_pad_s q_o
);

   typedef struct packed {
      upc_pad_s meta;
      upc_pad_s stable;
   } upc_sync_state_s;

   upc_sync_state_s state_reg;
   upc_sync_state_s state_next;

   // The first stage feeds only the second stage
   always_comb begin
      state_next = state_reg;
      state_next.meta = d_i;
      state_next.stable = state_reg.meta;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign q_o = state_reg.stable;

endmodule // upc_sync2
`default_nettype wire

// *** design/upc_pad_regulator_ctrl.sv ***
// USB pad transceiver and 3.3V regulator control registers with pad steering
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Transceiver config bit 7 connects D- pull-up
// - Pull-up returns to regulator when enabled
// - Force bit drives D-/D+ from pins 1/0
// - Force clear leaves transceiver in control
// - Forcing only while USB is enabled
// - PS/2 options never come from these bits
// - Regulator control bit 0 switches regulator output
// - Regulator enable takes port 1 pin 2
// - Alternate drive pins 3-6 need regulator
// - Regulator control bit 1 selects keep-alive
// - USB disable powers the transceiver down
module upc_pad_regulator_ctrl
   import upc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire upc_bus_req_s bus_i,
   output logic [UPC_DATA_W-1:0] rd_data_o,
   // Context from the rest of the USB block, same clock
   input wire logic usb_enable_i,
   input wire logic usb_mode_i,
   input wire logic port1_pin0_i,
   input wire logic port1_pin1_i,
   input wire logic [UPC_ALT_PINS-1:0] alt_drive_req_i,
   input wire upc_pad_drive_s sie_drive_i,
   output upc_pad_s sie_rx_o,
   // USB bus pins
   input wire logic dp_i,
   input wire logic dm_i,
   output logic dp_o,
   output logic dm_o,
   output logic dp_oe_n_o,
   output logic dm_oe_n_o,
   // Analog pad and regulator controls
   output logic pullup_en_o,
   output logic pullup_from_regulator_o,
   output logic xcvr_power_down_o,
   output logic regulator_en_o,
   output logic keep_alive_o,
   output logic port1_pin2_gpio_dis_o,
   output logic [UPC_ALT_PINS-1:0] alt_drive_en_o
);

   // Every flip-flop of the block except the u_rx_sync receive synchroniser lives in this one struct
   typedef struct packed {
      logic pullup_enable;
      logic force_state;
      logic regulator_enable;
      logic keep_alive;
      logic [UPC_DATA_W-1:0] rd_data;
      logic pad_dp;
      logic pad_dm;
      logic pad_oe_n;
      logic force_active;
      logic pullup_on;
      logic pullup_from_regulator;
      logic power_down;
      logic gpio_taken;
      logic [UPC_ALT_PINS-1:0] alt_drive;
   } upc_ctrl_state_s;

   upc_ctrl_state_s state_reg;
   upc_ctrl_state_s state_next;

   upc_pad_s pad_raw;
   upc_pad_s pad_sync;

   logic hit_regulator;
   logic hit_transceiver;
   logic hit_status;
   logic [UPC_DATA_W-1:0] regulator_view;
   logic [UPC_DATA_W-1:0] transceiver_view;
   logic [UPC_DATA_W-1:0] status_view;
   logic [UPC_ALT_PINS-1:0] alt_gate;

   // Pins arrive from the cable and are asynchronous to clk_i
   assign pad_raw.dp = dp_i;
   assign pad_raw.dm = dm_i;

   upc_sync2 u_rx_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i(pad_raw),
      .q_o(pad_sync)
   );

   // Address decode
   assign hit_regulator = (bus_i.addr == UPC_OFF_REGULATOR_CONTROL);
   assign hit_transceiver = (bus_i.addr == UPC_OFF_TRANSCEIVER_CONFIG);
   assign hit_status = (bus_i.addr == UPC_OFF_PAD_STATUS);

   // Read views: only the defined fields carry data, the rest is zero
   always_comb begin
      regulator_view = '0;
      regulator_view[UPC_REGULATOR_OUTPUT_ENABLE_BIT] = state_reg.regulator_enable;
      regulator_view[UPC_REGULATOR_OUTPUT_KEEP_ALIVE_BIT] = state_reg.keep_alive;
   end

   always_comb begin
      transceiver_view = '0;
      transceiver_view[UPC_XCVR_PULLUP_BIT] = state_reg.pullup_enable;
      transceiver_view[UPC_XCVR_FORCE_BIT] = state_reg.force_state;
   end

   // Status shows what the pads are really doing, not what was written
   always_comb begin
      status_view = '0;
      status_view[UPC_STAT_FORCE_ACTIVE_BIT] = state_reg.force_active;
      status_view[UPC_STAT_PULLUP_ON_BIT] = state_reg.pullup_on;
      status_view[UPC_STAT_POWER_DOWN_BIT] = state_reg.power_down;
      status_view[UPC_STAT_GPIO_TAKEN_BIT] = state_reg.gpio_taken;
   end

   // Alternate drive is granted per pin, only with the regulator up
   genvar alt_idx;
   generate
      for (alt_idx = 0; alt_idx < UPC_ALT_PINS; alt_idx++) begin : g_alt
         assign alt_gate[alt_idx] = alt_drive_req_i[alt_idx] & state_next.regulator_enable;
      end
   endgenerate

   always_comb begin
      state_next = state_reg;

      // Register writes; reserved bit positions are simply not stored
      if (bus_i.wr && hit_regulator) begin
         state_next.regulator_enable = bus_i.wdata[UPC_REGULATOR_OUTPUT_ENABLE_BIT];
         state_next.keep_alive = bus_i.wdata[UPC_REGULATOR_OUTPUT_KEEP_ALIVE_BIT];
      end
      if (bus_i.wr && hit_transceiver) begin
         state_next.pullup_enable = bus_i.wdata[UPC_XCVR_PULLUP_BIT];
         state_next.force_state = bus_i.wdata[UPC_XCVR_FORCE_BIT];
      end

      // Read data stand for exactly one cycle after the strobe
      state_next.rd_data = UPC_RST_READ_DATA;
      if (bus_i.rd) begin
         unique case (1'b1)
            hit_regulator: state_next.rd_data = regulator_view;
            hit_transceiver: state_next.rd_data = transceiver_view;
            hit_status: state_next.rd_data = status_view;
            default: state_next.rd_data = UPC_RST_READ_DATA;
         endcase
      end

      // Transceiver sleeps whenever the device address logic has USB off
      state_next.power_down = ~usb_enable_i;

      // Forcing needs USB enabled and the pads in USB mode, never PS/2
      state_next.force_active = state_next.force_state & usb_enable_i & usb_mode_i;

      // Pad drive selection
      if (state_next.power_down) begin
         // Powered-down transceiver releases both lines
         state_next.pad_dp = 1'b0;
         state_next.pad_dm = 1'b0;
         state_next.pad_oe_n = 1'b1;
      end else if (state_next.force_active) begin
         state_next.pad_dp = port1_pin0_i;
         state_next.pad_dm = port1_pin1_i;
         state_next.pad_oe_n = 1'b0;
      end else begin
         state_next.pad_dp = sie_drive_i.dp;
         state_next.pad_dm = sie_drive_i.dm;
         state_next.pad_oe_n = sie_drive_i.oe_n;
      end

      // Pull-up rail follows the regulator: supply when off, 3.3V when on
      state_next.pullup_on = state_next.pullup_enable;
      state_next.pullup_from_regulator = state_next.pullup_enable & state_next.regulator_enable;

      // Regulator owns port 1 pin 2 while enabled
      state_next.gpio_taken = state_next.regulator_enable;
      state_next.alt_drive = alt_gate;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_reg <= '0;
         state_reg.pullup_enable <= UPC_RST_TRANSCEIVER_CONFIG[UPC_XCVR_PULLUP_BIT];
         state_reg.force_state <= UPC_RST_TRANSCEIVER_CONFIG[UPC_XCVR_FORCE_BIT];
         state_reg.regulator_enable <= UPC_RST_REGULATOR_CONTROL[UPC_REGULATOR_OUTPUT_ENABLE_BIT];
         state_reg.keep_alive <= UPC_RST_REGULATOR_CONTROL[UPC_REGULATOR_OUTPUT_KEEP_ALIVE_BIT];
         // Lines stay released and the transceiver asleep during reset
         state_reg.pad_oe_n <= 1'b1;
         state_reg.power_down <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs
   assign rd_data_o = state_reg.rd_data;
   assign sie_rx_o = pad_sync;
   assign dp_o = state_reg.pad_dp;
   assign dm_o = state_reg.pad_dm;
   assign dp_oe_n_o = state_reg.pad_oe_n;
   assign dm_oe_n_o = state_reg.pad_oe_n;
   assign pullup_en_o = state_reg.pullup_on;
   assign pullup_from_regulator_o = state_reg.pullup_from_regulator;
   assign xcvr_power_down_o = state_reg.power_down;
   // Keep-alive only matters with the regulator off; the analog side limits it.
   // Software must clear port1_pin2_config bits 0 and 7 itself in that mode.
   assign keep_alive_o = state_reg.keep_alive;
   assign regulator_en_o = state_reg.regulator_enable;
   assign port1_pin2_gpio_dis_o = state_reg.gpio_taken;
   assign alt_drive_en_o = state_reg.alt_drive;

endmodule // upc_pad_regulator_ctrl
`default_nettype wire

// *** tb/upc_pad_checker.sv ***
// Checker: port-level assertions of the pad and regulator control block
`timescale 1ns/100ps
`default_nettype none
module upc_pad_checker
   import upc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire upc_bus_req_s bus_i,
   input wire logic usb_enable_i,
   input wire logic usb_mode_i,
   input wire logic port1_pin0_i,
   input wire logic port1_pin1_i,
   input wire logic [UPC_ALT_PINS-1:0] alt_drive_req_i,
   input wire upc_pad_drive_s sie_drive_i,
   input wire logic [UPC_DATA_W-1:0] rd_data_o,
   input wire logic dp_o,
   input wire logic dm_o,
   input wire logic dp_oe_n_o,
   input wire logic pullup_en_o,
   input wire logic pullup_from_regulator_o,
   input wire logic xcvr_power_down_o,
   input wire logic regulator_en_o,
   input wire logic keep_alive_o,
   input wire logic port1_pin2_gpio_dis_o,
   input wire logic [UPC_ALT_PINS-1:0] alt_drive_en_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic force_reg;
   logic wr_x;
   logic wr_v;
   logic force_next;
   assign wr_x = bus_i.wr && bus_i.addr == UPC_OFF_TRANSCEIVER_CONFIG;
   assign wr_v = bus_i.wr && bus_i.addr == UPC_OFF_REGULATOR_CONTROL;
   // A write at the same edge already steers the pads
   assign force_next = wr_x ? bus_i.wdata[0] : force_reg;
   always_ff @(posedge clk_i) force_reg <= rst_n_i ? force_next : 1'b0;
   AST_PULLUP: assert property (wr_x |=> pullup_en_o == $past(bus_i.wdata[7]))
      else $error("pull-up enable wrong");
   AST_RAIL: assert property (pullup_from_regulator_o == (pullup_en_o && regulator_en_o))
      else $error("pull-up rail wrong");
   AST_FORCE: assert property (usb_enable_i && usb_mode_i && force_next |=>
      dp_o == $past(port1_pin0_i) && dm_o == $past(port1_pin1_i) && !dp_oe_n_o) else $error("forced pins wrong");
   AST_SIE: assert property (usb_enable_i && !(usb_mode_i && force_next) |=>
      {dp_o, dm_o, dp_oe_n_o} == $past(sie_drive_i)) else $error("transceiver path wrong");
   AST_RELEASE: assert property (!usb_enable_i |=> dp_oe_n_o && !dp_o && !dm_o)
      else $error("lines not released");
   AST_REG_EN: assert property (wr_v |=> regulator_en_o == $past(bus_i.wdata[0]))
      else $error("regulator enable wrong");
   AST_GPIO: assert property (port1_pin2_gpio_dis_o == regulator_en_o)
      else $error("pin 2 takeover wrong");
   AST_ALT: assert property (1'b1 |=> alt_drive_en_o == ($past(alt_drive_req_i) & {UPC_ALT_PINS{regulator_en_o}}))
      else $error("alternate drive wrong");
   AST_KEEP: assert property (wr_v |=> keep_alive_o == $past(bus_i.wdata[1]))
      else $error("keep-alive wrong");
   AST_PWRDN: assert property (1'b1 |=> xcvr_power_down_o == !$past(usb_enable_i))
      else $error("power-down wrong");
   AST_RSVD: assert property (bus_i.rd && bus_i.addr == UPC_OFF_TRANSCEIVER_CONFIG |=> rd_data_o[6:1] == 6'h00)
      else $error("reserved bits read nonzero");
endmodule // upc_pad_checker
bind upc_pad_regulator_ctrl upc_pad_checker chk_u (.clk_i, .rst_n_i, .bus_i, .usb_enable_i, .usb_mode_i,
   .port1_pin0_i, .port1_pin1_i, .alt_drive_req_i, .sie_drive_i, .rd_data_o, .dp_o, .dm_o, .dp_oe_n_o,
   .pullup_en_o, .pullup_from_regulator_o, .xcvr_power_down_o, .regulator_en_o, .keep_alive_o,
   .port1_pin2_gpio_dis_o, .alt_drive_en_o);
`default_nettype wire

// *** tb/upc_usb_host.sv ***
// Host side model: resolves the D+/D- wires between device and host
`timescale 1ns/100ps
`default_nettype none
module upc_usb_host (
   input wire logic dp_o,
   input wire logic dm_o,
   input wire logic dp_oe_n_o,
   input wire logic dm_oe_n_o,
   input wire logic pullup_en_o,
   input wire logic host_drive_i,
   input wire logic host_dp_i,
   input wire logic host_dm_i,
   output logic dp_line_o,
   output logic dm_line_o
);
   // Undriven D- rests at the pull-up level, D+ at the host pull-down
   assign dp_line_o = !dp_oe_n_o ? dp_o : host_drive_i ? host_dp_i : 1'b0;
   assign dm_line_o = !dm_oe_n_o ? dm_o : host_drive_i ? host_dm_i : pullup_en_o;
endmodule // upc_usb_host
`default_nettype wire

// *** tb/usb_pad_and_regulator_ctrl_bench.sv ***
// Testbench of the pad and regulator control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module usb_pad_and_regulator_ctrl_bench
   import upc_pkg::*;
;
   typedef struct packed {
      logic [7:0] xc, vc;
      logic en, md, p0, p1;
      logic [2:0] sie;
      logic [3:0] alt, e_alt;
      logic [2:0] e_pad;
      logic [5:0] e_ctl;
   } upc_row_s;
   localparam upc_row_s ROWS [5] = '{
      '{8'hFF, 8'h00, 1, 1, 1, 0, 3'b000, 4'hF, 4'h0, 3'b100, 6'b100000},
      '{8'h81, 8'hFF, 1, 1, 0, 1, 3'b000, 4'hA, 4'hA, 3'b010, 6'b110111},
      '{8'h01, 8'h01, 1, 0, 1, 1, 3'b100, 4'h5, 4'h5, 3'b100, 6'b000101},
      // Keep-alive with the regulator off; software leaves port1_pin2_config bits 0 and 7 clear
      '{8'h00, 8'h02, 1, 1, 1, 1, 3'b011, 4'h0, 4'h0, 3'b011, 6'b000010},
      '{8'h81, 8'h01, 0, 1, 1, 1, 3'b100, 4'h3, 4'h3, 3'b001, 6'b111101}};
   logic clk_i = 0, rst_n_i = 0, en = 0, md = 0, p0 = 0, p1 = 0, hd = 0, hdp = 0, hdm = 0;
   logic dp, dm, dpoe, dmoe, pu, rail, pd, ven, ka, gd, dpl, dml;
   logic [3:0] alt = 4'h0, alten;
   logic [7:0] rdat;
   upc_bus_req_s bus = '0;
   upc_pad_drive_s sie = 3'b001;
   upc_pad_s rx;
   int n_mismatch = 0, checked = 0;
   always #5 clk_i = ~clk_i;
   upc_pad_regulator_ctrl dut_u (.clk_i, .rst_n_i, .bus_i(bus), .rd_data_o(rdat), .usb_enable_i(en),
      .usb_mode_i(md), .port1_pin0_i(p0), .port1_pin1_i(p1), .alt_drive_req_i(alt), .sie_drive_i(sie),
      .sie_rx_o(rx), .dp_i(dpl), .dm_i(dml), .dp_o(dp), .dm_o(dm), .dp_oe_n_o(dpoe), .dm_oe_n_o(dmoe),
      .pullup_en_o(pu), .pullup_from_regulator_o(rail), .xcvr_power_down_o(pd), .regulator_en_o(ven),
      .keep_alive_o(ka), .port1_pin2_gpio_dis_o(gd), .alt_drive_en_o(alten));
   upc_usb_host host_u (.dp_o(dp), .dm_o(dm), .dp_oe_n_o(dpoe), .dm_oe_n_o(dmoe), .pullup_en_o(pu),
      .host_drive_i(hd), .host_dp_i(hdp), .host_dm_i(hdm), .dp_line_o(dpl), .dm_line_o(dml));
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i) bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i) bus.rd <= 1'b0;
      #1 `CHK("read data", e, rdat)
   endtask
   task automatic end_of_test;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #100000 n_mismatch++;
      end_of_test;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      foreach (ROWS[i]) begin
         wr(UPC_OFF_TRANSCEIVER_CONFIG, ROWS[i].xc);
         wr(UPC_OFF_REGULATOR_CONTROL, ROWS[i].vc);
         {en, md, p0, p1, sie, alt} <= {ROWS[i].en, ROWS[i].md, ROWS[i].p0, ROWS[i].p1, ROWS[i].sie, ROWS[i].alt};
         repeat (2) @(posedge clk_i);
         #1 `CHK("pads", ROWS[i].e_pad, {dp, dm, dpoe})
         `CHK("d- enable", ROWS[i].e_pad[0], dmoe)
         `CHK("controls", ROWS[i].e_ctl, {pu, rail, pd, ven, ka, gd})
         `CHK("alt drive", ROWS[i].e_alt, alten)
         rd(UPC_OFF_TRANSCEIVER_CONFIG, ROWS[i].xc & 8'h81);
         rd(UPC_OFF_REGULATOR_CONTROL, ROWS[i].vc & 8'h03);
      end
      wr(UPC_OFF_TRANSCEIVER_CONFIG, 8'h00);
      @(posedge clk_i) bus <= '{UPC_OFF_TRANSCEIVER_CONFIG, 8'h81, 1'b1, 1'b0};
      @(posedge clk_i) bus <= '{UPC_OFF_TRANSCEIVER_CONFIG, 8'h00, 1'b0, 1'b1};
      #1 `CHK("pull-up after write", 1'b1, pu)
      @(posedge clk_i) bus <= '0;
      #1 `CHK("back-to-back read", 8'h81, rdat)
      @(posedge clk_i) #1 `CHK("read data idle", 8'h00, rdat)
      wr(8'h20, 8'hFF);
      wr(UPC_OFF_PAD_STATUS, 8'hFF);
      wr(UPC_OFF_TRANSCEIVER_CONFIG, 8'h80);
      rd(8'h20, 8'h00);
      rd(UPC_OFF_PAD_STATUS, 8'h0E);
      {hd, hdp, hdm} <= 3'b110;
      repeat (3) @(posedge clk_i);
      #1 `CHK("receive levels", 2'b10, rx)
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 `CHK("reset outputs", 4'b0011, {pu, ven, pd, dpoe})
      rst_n_i <= 1'b1;
      rd(UPC_OFF_TRANSCEIVER_CONFIG, UPC_RST_TRANSCEIVER_CONFIG);
      rd(UPC_OFF_REGULATOR_CONTROL, UPC_RST_REGULATOR_CONTROL);
      end_of_test;
   end
endmodule // usb_pad_and_regulator_ctrl_bench
`default_nettype wire
